// ### src/vt_failure_supervision.sv
// Purpose: Detect loss of the voltage transformer inputs and drive block and alarm outputs
// Assumes: sample_i pulses once per measurement sample, with meas_i valid in that cycle
// Notes:   Detectors and block outputs update together on the sample strobe; a flag clear write clears the flag unless a sample sees the condition that cycle
//
// Notes on behaviour
// - Negative sequence voltage without negative sequence current flags input failure.
// - V2 threshold 10V or 40V; I2 threshold settable 0.05-0.5 In, default 0.05.
// - All phase voltages collapsed and no superimposed current raises the condition.
// - Superimposed current is present sample minus sample one cycle earlier.
// - Phase voltage detectors pick up 30V, drop 10V; high rating 120V, 40V.
// - Superimposed current detectors use a fixed 0.1 In sensitivity.
// - Energizing with no voltages blocks only if the overcurrent inhibit stays off.
// - Energization path works only while the line is reported live.
// - Phase overcurrent detectors use a settable threshold and operate within 20ms.
// - Fast block follows any detected supervision condition.
// - Slow block output exists to suppress the any-pole-dead signal.
// - Indication output reports that a supervision operation has occurred.
// - Alarm output asserts only after a time delay following detection.
// - Slow block suppresses only voltage/current pole dead, never breaker-open pole dead.
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps

module vt_failure_supervision
  import vt_failure_supervision_pkg::*;
#(
  parameter longint OC_OPERATE_CYCLES = OC_OPERATE_CYC
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          nrst_i,
  // Measurement side
  input  wire logic          sample_i,
  input  wire meas_type      meas_i,
  input  wire logic          live_line_i,
  // Register port
  input  wire logic [7:0]    addr_i,
  input  wire logic [15:0]   wdata_i,
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  output logic      [15:0]   rdata_o,
  // Protection side
  output block_out_type      block_o
);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Threshold choice by input rating, used by several detectors
  function automatic logic [15:0] by_rating(input logic hi, input logic [15:0] std_v,
                                            input logic [15:0] hi_v);
    by_rating = hi ? hi_v : std_v;
  endfunction : by_rating

  // Keeps a written negative sequence current setting inside its legal range
  function automatic logic [15:0] clamp_i2(input logic [15:0] val);
    if (val < I2_SET_MIN) begin
      clamp_i2 = I2_SET_MIN;
    end else if (val > I2_SET_MAX) begin
      clamp_i2 = I2_SET_MAX;
    end else begin
      clamp_i2 = val;
    end
  endfunction : clamp_i2

  // Magnitude of the change between two signed samples
  function automatic logic [16:0] abs_delta(input logic [15:0] now_v, input logic [15:0] old_v);
    logic signed [16:0] d;
    d = $signed({now_v[15], now_v}) - $signed({old_v[15], old_v});
    abs_delta = d[16] ? 17'(-d) : 17'(d);
  endfunction : abs_delta

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic            high_rated;
    logic [15:0]     i2_set;
    logic [15:0]     oc_set;
    logic [15:0]     alarm_dly;
    logic [15:0]     alarm_cnt;
    alarm_state_type alm;
    logic [2:0]      v_det;
    logic            v2_det;
    logic            i2_det;
    logic [2:0]      di_det;
    logic [2:0]      oc_det;
    logic [PTR_W-1:0] ptr;
    logic            hist_full;
    logic            late;
    logic [31:0]     gap_cnt;
    block_out_type   out;
    logic [15:0]     rdata;
  } state_type;

  state_type s_reg;
  state_type s_next;

  logic [15:0] hist_mem [3][SAMPLES_PER_CYCLE];
  logic [2:0]  v_now;
  logic [2:0]  di_now;
  logic [2:0]  oc_now;
  logic        v2_now;
  logic        i2_now;
  logic        all_absent;
  logic        neg_now;
  logic        load_now;
  logic        ener_now;
  logic        cond_now;

  // ---------------------------------------------------------------------------
  // Per-phase detectors and one-cycle history
  // ---------------------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_phase
      // Hysteresis: pick up at the high level, hold until below the drop level
      assign v_now[p] = (meas_i.v_ph[p] >= by_rating(s_reg.high_rated, VPH_PICKUP_STD,
                                                     VPH_PICKUP_HIGH)) ? 1'b1 :
                        (meas_i.v_ph[p] <  by_rating(s_reg.high_rated, VPH_DROP_STD,
                                                     VPH_DROP_HIGH)) ? 1'b0 :
                        s_reg.v_det[p];
      // Until a whole cycle is stored the change is unknown, so assume a fault
      assign di_now[p] = !s_reg.hist_full ||
                         (abs_delta(meas_i.i_inst[p], hist_mem[p][s_reg.ptr]) >=
                          {1'b0, DI_THR});
      assign oc_now[p] = meas_i.i_mag[p] >= s_reg.oc_set;

      // History keeps one power-system cycle of samples per phase
      always_ff @(posedge clk_i) begin
        if (sample_i) begin
          hist_mem[p][s_reg.ptr] <= meas_i.i_inst[p];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Supervision decision
  // ---------------------------------------------------------------------------
  // Fault current keeps the negative sequence path stable
  assign v2_now     = meas_i.v2 >= by_rating(s_reg.high_rated, V2_THR_STD, V2_THR_HIGH);
  assign i2_now     = meas_i.i2 >= s_reg.i2_set;
  assign neg_now    = v2_now && !i2_now;
  assign all_absent = ~|v_now;
  assign load_now   = all_absent && !(|di_now);
  // A close-up fault picks up the inhibit detector and must be left to trip
  assign ener_now   = all_absent && live_line_i && !(|oc_now);
  assign cond_now   = neg_now || load_now || ener_now;

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    s_next       = s_reg;
    s_next.rdata = 16'h0000;

    // Register writes
    if (wr_i) begin
      case (addr_i)
        ADDR_CTRL: begin
          s_next.high_rated = wdata_i[CTRL_HIGH_RATED_BIT];
        end
        ADDR_I2_SET:    s_next.i2_set    = clamp_i2(wdata_i);
        ADDR_OC_SET:    s_next.oc_set    = wdata_i;
        ADDR_ALARM_DLY: s_next.alarm_dly = wdata_i;
        default: begin
        end
      endcase
    end

    // Clears from software, a new event in the same cycle wins below
    if (wr_i && addr_i == ADDR_CTRL && wdata_i[CTRL_FLAG_CLR_BIT]) begin
      s_next.out.supervision_flag = 1'b0;
    end
    if (wr_i && addr_i == ADDR_CTRL && wdata_i[CTRL_LATE_CLR_BIT]) begin
      s_next.late = 1'b0;
    end

    // Late sample watchdog: detectors can only answer within 20ms if samples keep coming
    if (sample_i) begin
      s_next.gap_cnt = 32'h0000_0000;
    end else if (s_reg.gap_cnt < 32'(OC_OPERATE_CYCLES)) begin
      s_next.gap_cnt = s_reg.gap_cnt + 32'h0000_0001;
    end else begin
      s_next.late = 1'b1;
    end

    // Evaluation once per sample
    if (sample_i) begin
      s_next.v_det     = v_now;
      s_next.v2_det    = v2_now;
      s_next.i2_det    = i2_now;
      s_next.di_det    = di_now;
      s_next.oc_det    = oc_now;
      s_next.ptr       = (s_reg.ptr == PTR_LAST) ? '0 : s_reg.ptr + PTR_W'(1);
      s_next.hist_full = s_reg.hist_full || (s_reg.ptr == PTR_LAST);

      s_next.out.fast_block_out = cond_now;
      // Slow block needs the condition on two samples in a row; it is meant only
      // for the undervoltage/undercurrent pole dead terms, breaker-open is untouched
      s_next.out.slow_block_out = cond_now && s_reg.out.fast_block_out;
      if (cond_now) begin
        s_next.out.supervision_flag = 1'b1;
      end

      // Alarm timer restarts whenever the condition drops before expiry
      case (s_reg.alm)
        ALM_IDLE: begin
          s_next.alarm_cnt = 16'h0000;
          if (cond_now) begin
            s_next.alm = ALM_TIMING;
          end
        end
        ALM_TIMING: begin
          if (!cond_now) begin
            s_next.alm       = ALM_IDLE;
            s_next.alarm_cnt = 16'h0000;
          end else if (s_reg.alarm_cnt + 16'h0001 >= s_reg.alarm_dly) begin
            s_next.alm       = ALM_ACTIVE;
            s_next.out.alarm = 1'b1;
          end else begin
            s_next.alarm_cnt = s_reg.alarm_cnt + 16'h0001;
          end
        end
        ALM_ACTIVE: begin
          if (!cond_now) begin
            s_next.alm       = ALM_IDLE;
            s_next.out.alarm = 1'b0;
          end
        end
        default: begin
          s_next.alm       = ALM_IDLE;
          s_next.out.alarm = 1'b0;
        end
      endcase
    end

    // Register reads, data stands for one cycle only
    if (rd_i) begin
      case (addr_i)
        ADDR_CTRL:      s_next.rdata = {15'h0000, s_reg.high_rated};
        ADDR_I2_SET:    s_next.rdata = s_reg.i2_set;
        ADDR_OC_SET:    s_next.rdata = s_reg.oc_set;
        ADDR_ALARM_DLY: s_next.rdata = s_reg.alarm_dly;
        ADDR_STATUS:    s_next.rdata = {s_reg.oc_det, s_reg.di_det, s_reg.v_det,
                                        s_reg.i2_det, s_reg.v2_det, s_reg.late,
                                        s_reg.out.alarm, s_reg.out.supervision_flag,
                                        s_reg.out.slow_block_out,
                                        s_reg.out.fast_block_out};
        default:        s_next.rdata = 16'h0000;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_reg           <= '0;
      s_reg.i2_set    <= I2_SET_DEFAULT;
      s_reg.oc_set    <= OC_SET_DEFAULT;
      s_reg.alarm_dly <= ALARM_DLY_DEFAULT;
      s_reg.alm       <= ALM_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata_o = s_reg.rdata;
  assign block_o = s_reg.out;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  property p_neg_fails;
    sample_i && v2_now && !i2_now |=> block_o.fast_block_out && block_o.supervision_flag;
  endproperty
  a_neg_fails: assert property (p_neg_fails) else $error("neg seq loss not flagged");

  property p_v2_threshold;
    sample_i && !s_reg.high_rated && meas_i.v2 < V2_THR_STD |=> !s_reg.v2_det;
  endproperty
  a_v2_threshold: assert property (p_v2_threshold) else $error("v2 detect below 10V");

  property p_di_inhibits;
    sample_i && (|di_now) && !neg_now && !ener_now |=> !block_o.fast_block_out;
  endproperty
  a_di_inhibits: assert property (p_di_inhibits) else $error("block despite fault");

  property p_hysteresis;
    sample_i && !s_reg.high_rated && meas_i.v_ph[0] >= VPH_DROP_STD &&
      meas_i.v_ph[0] < VPH_PICKUP_STD |=> s_reg.v_det[0] == $past(s_reg.v_det[0]);
  endproperty
  a_hysteresis: assert property (p_hysteresis) else $error("hysteresis band broken");

  property p_energize;
    sample_i && all_absent && live_line_i && (|oc_now) && !neg_now && !load_now
      |=> !block_o.fast_block_out;
  endproperty
  a_energize: assert property (p_energize) else $error("inhibit ignored");

  property p_dead_line;
    sample_i && !live_line_i && !neg_now && !load_now |=> !block_o.fast_block_out;
  endproperty
  a_dead_line: assert property (p_dead_line) else $error("block on dead line");

  property p_slow_after_fast;
    $rose(block_o.slow_block_out) |-> block_o.fast_block_out && $past(block_o.fast_block_out);
  endproperty
  a_slow_after_fast: assert property (p_slow_after_fast) else $error("slow block early");

  property p_alarm_delayed;
    $rose(block_o.alarm) |-> block_o.fast_block_out && $past(s_reg.alm == ALM_TIMING);
  endproperty
  a_alarm_delayed: assert property (p_alarm_delayed) else $error("alarm without delay");

  property p_alarm_restart;
    sample_i && !cond_now |=> s_reg.alm == ALM_IDLE && !block_o.alarm;
  endproperty
  a_alarm_restart: assert property (p_alarm_restart) else $error("alarm timer kept");

  property p_sample_only;
    !sample_i |=> $stable(block_o.fast_block_out) && $stable(block_o.slow_block_out);
  endproperty
  a_sample_only: assert property (p_sample_only) else $error("output off sample");

  // Fast block must mirror the condition seen at every sample
  property p_fast_follows;
    sample_i |=> block_o.fast_block_out == $past(cond_now);
  endproperty
  a_fast_follows: assert property (p_fast_follows) else $error("fast block stale");

  property p_flag_sets;
    sample_i && cond_now |=> block_o.supervision_flag;
  endproperty
  a_flag_sets: assert property (p_flag_sets) else $error("indication not set");

  c_neg_block:  cover property (sample_i && neg_now ##1 block_o.fast_block_out);
  c_load_block: cover property (sample_i && load_now && !neg_now);
  c_alarm:      cover property ($rose(block_o.alarm));
  c_energize:   cover property (sample_i && ener_now && !load_now);

endmodule : vt_failure_supervision

// ### src/vt_failure_supervision_pkg.sv
// Purpose: Shared constants and carriers for the voltage input failure supervision block
// Assumes: Voltages in units of 0.1 V, currents in units of In/1000, 16-bit magnitudes
// Notes:   Register map sits on a plain strobe port with 16-bit data
package vt_failure_supervision_pkg;

  // ---------------------------------------------------------------------------
  // Level detector thresholds
  // ---------------------------------------------------------------------------
  localparam logic [15:0] V2_THR_STD      = 16'h0064; // 10 V
  localparam logic [15:0] V2_THR_HIGH     = 16'h0190; // 40 V
  localparam logic [15:0] VPH_PICKUP_STD  = 16'h012C; // 30 V
  localparam logic [15:0] VPH_DROP_STD    = 16'h0064; // 10 V
  localparam logic [15:0] VPH_PICKUP_HIGH = 16'h04B0; // 120 V
  localparam logic [15:0] VPH_DROP_HIGH   = 16'h0190; // 40 V
  localparam logic [15:0] I2_SET_MIN      = 16'h0032; // 0.05 In
  localparam logic [15:0] I2_SET_MAX      = 16'h01F4; // 0.5 In
  localparam logic [15:0] I2_SET_DEFAULT  = 16'h0032; // 0.05 In
  localparam logic [15:0] DI_THR          = 16'h0064; // 0.1 In, not settable
  localparam logic [15:0] OC_SET_DEFAULT  = 16'h04B0; // 1.2 In
  localparam logic [15:0] ALARM_DLY_DEFAULT = 16'h0064; // Samples

  // ---------------------------------------------------------------------------
  // Superimposed current history and timing
  // ---------------------------------------------------------------------------
  localparam int          SAMPLES_PER_CYCLE = 24;
  localparam int          PTR_W             = 5;
  localparam logic [4:0]  PTR_LAST          = 5'h17;
  localparam longint      CLK_HZ            = 125000000;
  localparam longint      OC_OPERATE_MS     = 20;
  localparam longint      OC_OPERATE_CYC    = (OC_OPERATE_MS * CLK_HZ) / 1000;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_I2_SET    = 8'h04;
  localparam logic [7:0] ADDR_OC_SET    = 8'h08;
  localparam logic [7:0] ADDR_ALARM_DLY = 8'h0C;
  localparam logic [7:0] ADDR_STATUS    = 8'h10;
  localparam int         CTRL_HIGH_RATED_BIT = 0;
  localparam int         CTRL_FLAG_CLR_BIT   = 1;
  localparam int         CTRL_LATE_CLR_BIT   = 2;

  // ---------------------------------------------------------------------------
  // Carriers and states
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [2:0][15:0] v_ph;    // Phase voltage magnitudes
    logic [15:0]      v2;      // Negative sequence voltage magnitude
    logic [15:0]      i2;      // Negative sequence current magnitude
    logic [2:0][15:0] i_inst;  // Phase current samples, two's complement
    logic [2:0][15:0] i_mag;   // Phase current magnitudes
  } meas_type;

  typedef struct packed {
    logic fast_block_out;
    logic slow_block_out;
    logic supervision_flag;
    logic alarm;
  } block_out_type;

  typedef enum logic [1:0] {
    ALM_IDLE   = 2'b00,
    ALM_TIMING = 2'b01,
    ALM_ACTIVE = 2'b10
  } alarm_state_type;

endpackage : vt_failure_supervision_pkg

// ### bench/meas_source.sv
// Purpose: Measurement side model that strobes samples and presents the quantities
// Assumes: The bench changes the quantities only while run_i is low
// Notes:   Between strobes the quantities are inverted so stale values never match
`timescale 1ns/1ps

module meas_source
  import vt_failure_supervision_pkg::*;
(
  // Clock, reset and control
  input  wire logic     clk_i,
  input  wire logic     nrst_i,
  input  wire logic     run_i,
  input  wire meas_type meas_i,
  // Toward the block
  output logic          sample_o,
  output meas_type      meas_o
);
  // -------------------------------------------------------------------------
  // Sample strobe
  // -------------------------------------------------------------------------
  // One pulse every other cycle, so gaps between samples are exercised too
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sample_o <= 1'b0;
    end else begin
      sample_o <= run_i & ~sample_o;
    end
  end

  // Quantities are only meaningful beside the strobe
  assign meas_o = sample_o ? meas_i : ~meas_i;
endmodule : meas_source

// ### bench/vt_failure_supervision_bench.sv
// Purpose: Self-checking bench for the voltage input failure supervision block
// Assumes: Overcurrent timeout shortened to 200 clocks
// Notes:   Each step applies samples, then compares the block outputs as fast,slow,flag,alarm
`timescale 1ns/1ps

module vt_failure_supervision_bench;
  import vt_failure_supervision_pkg::*;
  localparam longint OC_SIM = 200;
  logic          clk_i, nrst_i, run, sample_i, live_line_i, wr_i, rd_i;
  logic [7:0]    addr_i;
  logic [15:0]   wdata_i, rdata_o;
  meas_type      m, meas_i;
  block_out_type block_o;
  int            n_errors, checked;

  // -------------------------------------------------------------------------
  // Instances and clock
  // -------------------------------------------------------------------------
  vt_failure_supervision #(.OC_OPERATE_CYCLES(OC_SIM)) vt_failure_supervision_i (
    .clk_i(clk_i), .nrst_i(nrst_i), .sample_i(sample_i), .meas_i(meas_i),
    .live_line_i(live_line_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .block_o(block_o));
  meas_source meas_source_i (.clk_i(clk_i), .nrst_i(nrst_i), .run_i(run), .meas_i(m),
    .sample_o(sample_i), .meas_o(meas_i));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // -------------------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] got);
    checked++;
    if (got !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, e, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so look there
  task automatic rd(input logic [7:0] a, input logic [15:0] msk, input logic [15:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 chk("rdata_o", e, rdata_o & msk);
  endtask : rd

  // Apply n samples under a bounded wait, then compare the outputs
  task automatic smp(input int n, input logic [3:0] e);
    int cnt;
    int lim;
    cnt = 0;
    lim = 0;
    run <= 1'b1;
    while (cnt < n && lim < 4 * n + 20) begin
      @(posedge clk_i);
      lim++;
      if (sample_i === 1'b1) cnt++;
    end
    run <= 1'b0;
    if (cnt < n) begin
      n_errors++;
      summarize();
    end
    #1 chk("block_o", {12'h000, e}, {12'h000, block_o});
  endtask : smp

  // -------------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------------
  initial begin
    n_errors = 0;
    checked = 0;
    run = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 16'h0000;
    nrst_i = 1'b0;
    live_line_i = 1'b0;
    m = '0;
    m.v_ph = {3{16'h0384}};
    m.i_inst = {3{16'h0100}};
    m.i_mag = {3{16'h0100}};
    repeat (12) @(posedge clk_i);
    chk("block_o", 16'h0000, {12'h000, block_o});
    nrst_i <= 1'b1;
    rd(ADDR_I2_SET, 16'hFFFF, 16'h0032);
    rd(ADDR_OC_SET, 16'hFFFF, 16'h04B0);
    rd(ADDR_ALARM_DLY, 16'hFFFF, 16'h0064);
    rd(8'h14, 16'hFFFF, 16'h0000);
    smp(30, 4'b0000);
    // Negative sequence path with a short alarm delay
    wr(ADDR_ALARM_DLY, 16'h0003);
    m.v2 <= 16'h0064;
    smp(1, 4'b1010);
    smp(2, 4'b1110);
    smp(1, 4'b1111);
    m.v2 <= 16'h0063;
    smp(1, 4'b0010);
    m.v2 <= 16'h0064;
    smp(3, 4'b1110);
    m.v2 <= 16'h0063;
    smp(1, 4'b0010);
    wr(ADDR_CTRL, 16'h0002);
    #1 chk("block_o", 16'h0000, {12'h000, block_o});
    // Negative sequence current holds the block off at its setting
    m.v2 <= 16'h0064;
    m.i2 <= 16'h0032;
    smp(1, 4'b0000);
    m.i2 <= 16'h0031;
    smp(1, 4'b1010);
    m.v2 <= 16'h0000;
    m.i2 <= 16'h0000;
    // A clean sample breaks the run, so the next condition starts without slow block
    smp(1, 4'b0010);
    wr(ADDR_I2_SET, 16'h0100);
    rd(ADDR_I2_SET, 16'hFFFF, 16'h0100);
    wr(ADDR_I2_SET, 16'h0600);
    rd(ADDR_I2_SET, 16'hFFFF, 16'h01F4);
    wr(ADDR_I2_SET, 16'h0000);
    rd(ADDR_I2_SET, 16'hFFFF, 16'h0032);
    // Three phase collapse with steady load and the voltage hysteresis
    m.v_ph <= {3{16'h0063}};
    smp(1, 4'b1010);
    m.v_ph <= {3{16'h012B}};
    smp(2, 4'b1110);
    m.v_ph <= {3{16'h012C}};
    smp(1, 4'b0010);
    m.v_ph <= {3{16'h0065}};
    smp(1, 4'b0010);
    m.v_ph <= {3{16'h0063}};
    smp(1, 4'b1010);
    // Superimposed current just under and at its fixed sensitivity
    m.i_inst <= {3{16'h0163}};
    smp(1, 4'b1110);
    m.i_inst[1] <= 16'h0164;
    smp(1, 4'b0010);
    // Energization: one phase at the setting suppresses the block
    live_line_i <= 1'b1;
    m.i_mag[2] <= 16'h04B0;
    smp(1, 4'b0010);
    m.i_mag[2] <= 16'h04AF;
    smp(1, 4'b1010);
    live_line_i <= 1'b0;
    smp(1, 4'b0010);
    wr(ADDR_OC_SET, 16'h0200);
    rd(ADDR_OC_SET, 16'hFFFF, 16'h0200);
    // Samples stop for longer than the operate limit
    repeat (OC_SIM + 10) @(posedge clk_i);
    rd(ADDR_STATUS, 16'h0010, 16'h0010);
    // Samples must resume first, or the watchdog sets late again over the clear
    smp(1, 4'b0010);
    wr(ADDR_CTRL, 16'h0004);
    rd(ADDR_STATUS, 16'h0010, 16'h0000);
    // High rated inputs move the negative sequence threshold
    m.v_ph <= {3{16'h0384}};
    m.v2 <= 16'h018F;
    wr(ADDR_CTRL, 16'h0003);
    smp(1, 4'b0000);
    m.v2 <= 16'h0190;
    smp(1, 4'b1010);
    // Reset in mid-run clears outputs and restores default settings
    @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    #1 chk("block_o", 16'h0000, {12'h000, block_o});
    rd(ADDR_OC_SET, 16'hFFFF, 16'h04B0);
    summarize();
  end
endmodule : vt_failure_supervision_bench
